// *** rfw_regs.svh ***
// register map, field positions, reset values and counts of the window decode
`ifndef RFW_REGS_SVH
`define RFW_REGS_SVH

// register byte addresses on the processor bus
`define RFW_ADDR_WIN_A     32'hFEF80050
`define RFW_ADDR_WIN_B     32'hFEF80058
`define RFW_WORD_LSB       2

// field positions, bus bit 0 is the msb of the 32-bit word
`define RFW_BASE_HI        31
`define RFW_BASE_LO        20
`define RFW_WIDTH_BIT      19
`define RFW_SIZ_HI         18
`define RFW_SIZ_LO         16
`define RFW_VEC_BIT        2
`define RFW_EN_BIT         1
`define RFW_WE_BIT         0

// reset values
`define RFW_BASE_RST_A     12'hFF0
`define RFW_BASE_RST_B     12'hFF4
`define RFW_SIZ_RST        3'h0
`define RFW_SIZ_RSVD       3'h7

// address space constants
`define RFW_VEC_PAGE       12'hFFF
`define RFW_MB_BITS        20
`define RFW_PAGE_ZERO      6'h00

// transfer sizes accepted for writes
`define RFW_BYTES_ONE      6'h01
`define RFW_BYTES_FOUR     6'h04
`define RFW_ALIGN_ZERO     2'h0

// edges after release before the straps are caught: three flops fill,
// then the agreement stage needs one more edge to pass the level on
`define RFW_STRAP_SETTLE   4

`endif

// *** rfw_pkg.sv ***
// types shared by the flash window decode files
package rfw_pkg;

    // one processor bus request, valid for a single cycle
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
        logic [5:0]  nbytes;
        logic [31:0] wdata;
    } rfw_req_t;

    // software-visible settings of one flash block
    typedef struct packed {
        logic [11:0] base;
        logic [2:0]  siz;
        logic        vec;
        logic        en;
        logic        we;
    } rfw_win_t;

    // strobe towards the flash data path
    typedef struct packed {
        logic        sel_a;
        logic        sel_b;
        logic        write;
        logic [25:0] offset;
    } rfw_mem_t;

    // strap capture sequence
    typedef enum logic [1:0] {
        RFW_SETTLE = 2'b01,
        RFW_DONE   = 2'b10
    } rfw_strap_state_t;

endpackage : rfw_pkg

// *** rfw_sync3.sv ***
// three-stage synchroniser that passes a change once stages two and three agree
module rfw_sync3 #(
    parameter int W = 4
) (
    input  wire logic         sys_clk,  // bus clock
    input  wire logic         rst_n,    // power-up reset, active low
    input  wire logic [W-1:0] pin_in,   // raw asynchronous pins
    output logic      [W-1:0] sync_out  // filtered, synchronised value
);

    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;
    logic [W-1:0] next_sync_out;

    if (W < 1) begin : g_chk
        $error("rfw_sync3: W must be at least 1");
    end

    // stage one is read only by stage two
    always_comb begin
        next_sync_out = sync_out;
        for (int i = 0; i < W; i++) begin
            if (stage2[i] == stage3[i]) begin
                next_sync_out[i] = stage3[i];
            end
        end
    end

    // capture chain
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1   <= '0;
            stage2   <= '0;
            stage3   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= pin_in;
            stage2   <= stage1;
            stage3   <= stage2;
            sync_out <= next_sync_out;
        end
    end

endmodule : rfw_sync3

// *** rfw_window.sv ***
// address match of one flash block: programmed window and top-megabyte alias
`include "rfw_regs.svh"
module rfw_window (
    input  wire rfw_pkg::rfw_win_t cfg,       // block settings
    input  wire logic              vec_own,   // block serves the top page
    input  wire logic [31:0]       addr,      // processor address
    output logic                   win_hit,   // programmed window matches
    output logic                   vec_hit,   // top-page alias matches
    output logic [25:0]            offset     // byte offset inside block
);

    logic [11:0] base_mask;
    logic [25:0] ofs_mask;
    logic [11:0] page;

    // larger sizes drop low base bits, keeping windows size-aligned
    always_comb begin
        page      = addr[`RFW_BASE_HI:`RFW_BASE_LO];
        base_mask = ~(12'((12'h001 << cfg.siz) - 12'h001));
        ofs_mask  = 26'((64'h1 << (`RFW_MB_BITS + 32'(cfg.siz))) - 64'h1);
        // reserved size code matches no programmed window; the top-page alias still matches
        win_hit   = cfg.en && (cfg.siz != `RFW_SIZ_RSVD) &&
                    (((page ^ cfg.base) & base_mask) == 12'h000);
        vec_hit   = vec_own && (page == `RFW_VEC_PAGE);
        if (vec_hit) begin
            offset = {`RFW_PAGE_ZERO, addr[`RFW_MB_BITS-1:0]};
        end else begin
            offset = addr[25:0] & ofs_mask;
        end
    end

endmodule : rfw_window

// *** rfw_decode.sv ***
// flash block a/b window registers, decode and write acceptance
`include "rfw_regs.svh"
//
// How it works
// - each base's twelve bits compare with address bits 0 to 11
// - larger sizes ignore low base bits so windows align to size
// - power-up or local reset sets base a to FF0, b to FF4
// - size codes 0 to 6 mean 1 to 64 MB, code 7 reserved
// - width flags come from straps at power-up, software cannot change
// - flag clear means 16-bit block, set means 64-bit block
// - top megabyte: none, a when only a selected, b whenever b selected
// - selected block's first megabyte also answers in the top megabyte
// - vector select bits load from straps at power-up
// - programmed window answers only while its access enable is set
// - memory writes happen only while the write enable is set
// - 16-bit blocks accept byte writes, 64-bit blocks aligned words
// - every other write size or alignment gets no response
// - valid write with write enable clear ends normally, no change
module rfw_decode (
    input  wire logic              sys_clk,        // bus clock, 40 MHz
    input  wire logic              rst_n,          // power-up reset
    input  wire logic              lbr_n,          // local bus reset, sync
    input  wire logic              strap_vector_a, // vector select a strap
    input  wire logic              strap_vector_b, // vector select b strap
    input  wire logic              strap_width_a,  // width a strap
    input  wire logic              strap_width_b,  // width b strap
    input  wire rfw_pkg::rfw_req_t bus_req,        // processor request
    output logic                   rsp_ack,        // normal termination
    output logic [31:0]            rsp_rdata,      // register read data
    output rfw_pkg::rfw_mem_t      mem_cmd,        // flash access strobe
    output logic                   straps_ready    // straps have been caught
);

    localparam int STRAP_SETTLE = `RFW_STRAP_SETTLE;

    if (STRAP_SETTLE < 1 || STRAP_SETTLE > 7) begin : g_chk
        $error("rfw_decode: strap settle count must be 1 to 7");
    end

    // register image of one block, reserved bits forced to zero
    function automatic logic [31:0] reg_image(
        input rfw_pkg::rfw_win_t w,
        input logic              wide
    );
        logic [31:0] img;
        img = 32'h0000_0000;
        img[`RFW_BASE_HI:`RFW_BASE_LO] = w.base;
        img[`RFW_WIDTH_BIT]            = wide;
        img[`RFW_SIZ_HI:`RFW_SIZ_LO]   = w.siz;
        img[`RFW_VEC_BIT]              = w.vec;
        img[`RFW_EN_BIT]               = w.en;
        img[`RFW_WE_BIT]               = w.we;
        return img;
    endfunction : reg_image

    // write size acceptable for the block's data width
    function automatic logic write_ok(
        input logic        wide,
        input logic [5:0]  nbytes,
        input logic [31:0] addr
    );
        logic ok;
        ok = 1'b0;
        if (!wide) begin
            ok = (nbytes == `RFW_BYTES_ONE);
        end else begin
            ok = (nbytes == `RFW_BYTES_FOUR) &&
                 (addr[1:0] == `RFW_ALIGN_ZERO);
        end
        return ok;
    endfunction : write_ok

    // word address match of a register
    function automatic logic reg_match(
        input logic [31:0] addr,
        input logic [31:0] reg_addr
    );
        return addr[31:`RFW_WORD_LSB] == reg_addr[31:`RFW_WORD_LSB];
    endfunction : reg_match

    logic [3:0] strap_sync;

    // straps are pins, so they pass the three-stage filter first
    rfw_sync3 #(
        .W (4)
    ) u_strap_sync (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .pin_in   ({strap_width_b, strap_width_a,
                    strap_vector_b, strap_vector_a}),
        .sync_out (strap_sync)
    );

    // ---- strap capture after power-up release
    rfw_pkg::rfw_strap_state_t strap_state;
    rfw_pkg::rfw_strap_state_t next_strap_state;
    logic [2:0]                settle_cnt;
    logic [2:0]                next_settle_cnt;
    logic                      width_a;
    logic                      width_b;
    logic                      next_width_a;
    logic                      next_width_b;
    logic                      next_straps_ready;
    logic                      strap_load;

    // wait for the filter to fill, then catch the straps exactly once
    always_comb begin
        next_strap_state  = strap_state;
        next_settle_cnt   = settle_cnt;
        next_width_a      = width_a;
        next_width_b      = width_b;
        next_straps_ready = straps_ready;
        strap_load        = 1'b0;
        case (strap_state)
            rfw_pkg::RFW_SETTLE: begin
                if (settle_cnt == 3'(STRAP_SETTLE)) begin
                    strap_load        = 1'b1;
                    next_width_a      = strap_sync[2];
                    next_width_b      = strap_sync[3];
                    next_straps_ready = 1'b1;
                    next_strap_state  = rfw_pkg::RFW_DONE;
                end else begin
                    next_settle_cnt = 3'(settle_cnt + 3'h1);
                end
            end
            rfw_pkg::RFW_DONE: begin
                next_strap_state = rfw_pkg::RFW_DONE;
            end
            default: begin
                next_strap_state = rfw_pkg::RFW_SETTLE;
            end
        endcase
    end

    // only power-up reset restarts the capture; local reset leaves it
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_state  <= rfw_pkg::RFW_SETTLE;
            settle_cnt   <= 3'h0;
            width_a      <= 1'b0;
            width_b      <= 1'b0;
            straps_ready <= 1'b0;
        end else begin
            strap_state  <= next_strap_state;
            settle_cnt   <= next_settle_cnt;
            width_a      <= next_width_a;
            width_b      <= next_width_b;
            straps_ready <= next_straps_ready;
        end
    end

    // ---- address decode of the current request
    rfw_pkg::rfw_win_t win_a;
    rfw_pkg::rfw_win_t win_b;
    logic              vec_own_a;
    logic              vec_own_b;
    logic              win_hit_a;
    logic              win_hit_b;
    logic              vec_hit_a;
    logic              vec_hit_b;
    logic [25:0]       ofs_a;
    logic [25:0]       ofs_b;

    // b wins the top page whenever it is selected
    assign vec_own_b = win_b.vec;
    assign vec_own_a = win_a.vec && !win_b.vec;

    rfw_window u_win_a (
        .cfg     (win_a),
        .vec_own (vec_own_a),
        .addr    (bus_req.addr),
        .win_hit (win_hit_a),
        .vec_hit (vec_hit_a),
        .offset  (ofs_a)
    );

    rfw_window u_win_b (
        .cfg     (win_b),
        .vec_own (vec_own_b),
        .addr    (bus_req.addr),
        .win_hit (win_hit_b),
        .vec_hit (vec_hit_b),
        .offset  (ofs_b)
    );

    logic reg_a;
    logic reg_b;
    logic reg_wr_ok;
    logic hit_a;
    logic hit_b;

    // register space takes priority over any flash window
    always_comb begin
        reg_a     = reg_match(bus_req.addr, `RFW_ADDR_WIN_A);
        reg_b     = reg_match(bus_req.addr, `RFW_ADDR_WIN_B);
        reg_wr_ok = (bus_req.nbytes == `RFW_BYTES_FOUR) &&
                    (bus_req.addr[1:0] == `RFW_ALIGN_ZERO);
        hit_a     = !reg_a && !reg_b && (win_hit_a || vec_hit_a);
        hit_b     = !reg_a && !reg_b && !hit_a && (win_hit_b || vec_hit_b);
    end

    // ---- base/size registers
    rfw_pkg::rfw_win_t next_win_a;
    rfw_pkg::rfw_win_t next_win_b;

    // software writes, local reset and the one-time strap load
    always_comb begin
        next_win_a = win_a;
        next_win_b = win_b;
        if (bus_req.valid && bus_req.write && reg_wr_ok) begin
            // width flag and reserved bits are not writable
            if (reg_a) begin
                next_win_a.base = bus_req.wdata[`RFW_BASE_HI:`RFW_BASE_LO];
                next_win_a.siz  = bus_req.wdata[`RFW_SIZ_HI:`RFW_SIZ_LO];
                next_win_a.vec  = bus_req.wdata[`RFW_VEC_BIT];
                next_win_a.en   = bus_req.wdata[`RFW_EN_BIT];
                next_win_a.we   = bus_req.wdata[`RFW_WE_BIT];
            end
            if (reg_b) begin
                next_win_b.base = bus_req.wdata[`RFW_BASE_HI:`RFW_BASE_LO];
                next_win_b.siz  = bus_req.wdata[`RFW_SIZ_HI:`RFW_SIZ_LO];
                next_win_b.vec  = bus_req.wdata[`RFW_VEC_BIT];
                next_win_b.en   = bus_req.wdata[`RFW_EN_BIT];
                next_win_b.we   = bus_req.wdata[`RFW_WE_BIT];
            end
        end
        // strap load beats a software write in the same cycle
        if (strap_load) begin
            next_win_a.vec = strap_sync[0];
            next_win_b.vec = strap_sync[1];
        end
        // local reset keeps the vector selects, returns base, size and enables to reset values
        if (!lbr_n) begin
            next_win_a.base = `RFW_BASE_RST_A;
            next_win_b.base = `RFW_BASE_RST_B;
            next_win_a.siz  = `RFW_SIZ_RST;
            next_win_b.siz  = `RFW_SIZ_RST;
            next_win_a.en   = 1'b0;
            next_win_b.en   = 1'b0;
            next_win_a.we   = 1'b0;
            next_win_b.we   = 1'b0;
        end
    end

    // register storage
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            win_a <= '{base: `RFW_BASE_RST_A, siz: `RFW_SIZ_RST,
                       vec: 1'b0, en: 1'b0, we: 1'b0};
            win_b <= '{base: `RFW_BASE_RST_B, siz: `RFW_SIZ_RST,
                       vec: 1'b0, en: 1'b0, we: 1'b0};
        end else begin
            win_a <= next_win_a;
            win_b <= next_win_b;
        end
    end

    // ---- response and flash strobe, one cycle after the request
    logic              next_rsp_ack;
    logic [31:0]       next_rsp_rdata;
    rfw_pkg::rfw_mem_t next_mem_cmd;
    logic              wr_ok_a;
    logic              wr_ok_b;

    // silence on a refused write lets the bus time the cycle out
    always_comb begin
        next_rsp_ack   = 1'b0;
        next_rsp_rdata = 32'h0000_0000;
        next_mem_cmd   = '0;
        wr_ok_a = write_ok(width_a, bus_req.nbytes, bus_req.addr);
        wr_ok_b = write_ok(width_b, bus_req.nbytes, bus_req.addr);
        if (bus_req.valid) begin
            if (reg_a || reg_b) begin
                // registers answer reads of any size, word writes only
                next_rsp_ack = !bus_req.write || reg_wr_ok;
                if (!bus_req.write) begin
                    next_rsp_rdata = reg_a ? reg_image(win_a, width_a)
                                           : reg_image(win_b, width_b);
                end
            end else if (!bus_req.write) begin
                next_rsp_ack       = hit_a || hit_b;
                next_mem_cmd.sel_a = hit_a;
                next_mem_cmd.sel_b = hit_b;
            end else if (hit_a && wr_ok_a) begin
                next_rsp_ack       = 1'b1;
                next_mem_cmd.sel_a = win_a.we;
                next_mem_cmd.write = win_a.we;
            end else if (hit_b && wr_ok_b) begin
                next_rsp_ack       = 1'b1;
                next_mem_cmd.sel_b = win_b.we;
                next_mem_cmd.write = win_b.we;
            end
            if (next_mem_cmd.sel_a) begin
                next_mem_cmd.offset = ofs_a;
            end else if (next_mem_cmd.sel_b) begin
                next_mem_cmd.offset = ofs_b;
            end
        end
    end

    // registered outputs
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_ack   <= 1'b0;
            rsp_rdata <= 32'h0000_0000;
            mem_cmd   <= '0;
        end else begin
            rsp_ack   <= next_rsp_ack;
            rsp_rdata <= next_rsp_rdata;
            mem_cmd   <= next_mem_cmd;
        end
    end

endmodule : rfw_decode

// *** rfw_decode_properties.sv ***
// checker of the flash window decode, bound to its top module
module rfw_decode_properties (
    input wire logic              sys_clk,      // bus clock
    input wire logic              rst_n,        // power-up reset
    input wire rfw_pkg::rfw_req_t bus_req,      // processor request
    input wire logic              rsp_ack,      // normal termination
    input wire logic [31:0]       rsp_rdata,    // register read data
    input wire rfw_pkg::rfw_mem_t mem_cmd,      // flash strobe
    input wire logic              straps_ready  // straps caught
);
    default clocking cb_sys @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    rfw_pkg::rfw_req_t prev_req;
    logic              wr;
    logic              is_reg;
    logic              sel;

    // request taken last edge, so answers can be tied to their cause
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_req <= '0;
        end else begin
            prev_req <= bus_req;
        end
    end

    // both window registers share one 16-byte row, word 0 or 2
    assign wr     = bus_req.valid && bus_req.write;
    assign is_reg = bus_req.addr[31:4] == 28'hFEF8005 && !bus_req.addr[2];
    assign sel    = mem_cmd.sel_a || mem_cmd.sel_b;

    chk_bad_size: assert property (
        wr && !(bus_req.nbytes inside {6'h01, 6'h04}) |=> !rsp_ack)
        else $error("odd write size answered");
    chk_misaligned: assert property (
        wr && bus_req.nbytes == 6'h04 && bus_req.addr[1:0] != 2'h0
        |=> !rsp_ack) else $error("misaligned write answered");
    chk_reg_read: assert property (
        bus_req.valid && !bus_req.write && is_reg
        |=> rsp_ack && rsp_rdata[15:3] == 13'h0000)
        else $error("register read wrong");
    chk_strobe_cause: assert property (
        mem_cmd.write |-> rsp_ack && sel && prev_req.valid && prev_req.write)
        else $error("flash write without cause");
    chk_write_size: assert property (
        mem_cmd.write |-> prev_req.nbytes == 6'h01 ||
        (prev_req.nbytes == 6'h04 && prev_req.addr[1:0] == 2'h0))
        else $error("flash write of illegal size");
    chk_ack_cause: assert property (
        rsp_ack |-> prev_req.valid) else $error("answer without request");
    chk_one_block: assert property (
        !(mem_cmd.sel_a && mem_cmd.sel_b)) else $error("both blocks chosen");
    chk_sel_ack: assert property (
        sel |-> rsp_ack && $past(bus_req.valid))
        else $error("strobe without termination");
    chk_straps_hold: assert property (
        $rose(straps_ready) |=> straps_ready [*8])
        else $error("strap flag dropped");

    cover property (mem_cmd.write);
    cover property (rsp_ack && prev_req.addr[31:20] == 12'hFFF);
    cover property (prev_req.valid && prev_req.write && !rsp_ack);
endmodule : rfw_decode_properties

bind rfw_decode rfw_decode_properties i_props (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .bus_req     (bus_req),
    .rsp_ack     (rsp_ack),
    .rsp_rdata   (rsp_rdata),
    .mem_cmd     (mem_cmd),
    .straps_ready(straps_ready)
);

// *** rfw_bus_master.sv ***
// processor bus master model issuing one request at a time
module rfw_bus_master (
    input  wire logic              sys_clk,   // bus clock
    input  wire logic              rsp_ack,   // normal termination
    input  wire logic [31:0]       rsp_rdata, // read data
    input  wire rfw_pkg::rfw_mem_t mem_cmd,   // flash strobe
    output rfw_pkg::rfw_req_t      bus_req    // request to the decode
);
    timeunit 1ns;
    timeprecision 1ps;

    initial bus_req = '0;

    // valid stands one edge; released lines are inverted, never held
    task automatic xfer(input logic w, input logic [31:0] a,
                        input logic [5:0] n, input logic [31:0] d,
                        output logic ack, output logic [31:0] rd,
                        output rfw_pkg::rfw_mem_t mem);
        @(posedge sys_clk);
        bus_req <= {1'b1, w, a, n, d};
        @(posedge sys_clk);
        bus_req <= {1'b0, ~w, ~a, ~n, ~d};
        #1;
        ack = rsp_ack;
        rd = rsp_rdata;
        mem = mem_cmd;
    endtask : xfer
endmodule : rfw_bus_master

// *** rfw_decode_bench.sv ***
// self-checking bench of the flash window decode
`include "rfw_regs.svh"
module rfw_decode_bench;
    timeunit 1ns;
    timeprecision 1ps;
`define CHECK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

    logic              sys_clk, rst_n, lbr_n, rsp_ack, straps_ready, ack;
    logic [3:0]        strap;  // vector a, vector b, width a, width b
    logic [31:0]       rsp_rdata, rd, seed;
    rfw_pkg::rfw_req_t bus_req;
    rfw_pkg::rfw_mem_t mem_cmd, mem;
    rfw_pkg::rfw_win_t ca, cb;
    int                failures, checked, cycles;
    logic [5:0]        sizes [9] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05,
                                     6'h06, 6'h07, 6'h08, 6'h20};

    rfw_decode i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .lbr_n(lbr_n),
        .strap_vector_a(strap[3]), .strap_vector_b(strap[2]),
        .strap_width_a(strap[1]), .strap_width_b(strap[0]),
        .bus_req(bus_req), .rsp_ack(rsp_ack), .rsp_rdata(rsp_rdata),
        .mem_cmd(mem_cmd), .straps_ready(straps_ready));
    rfw_bus_master i_master (.sys_clk(sys_clk), .rsp_ack(rsp_ack),
        .rsp_rdata(rsp_rdata), .mem_cmd(mem_cmd), .bus_req(bus_req));

    // 25 ns clock
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic final_report;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report

    // a hang is cut short well beyond the few thousand cycles needed
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            final_report();
        end
    end

    function automatic logic win(rfw_pkg::rfw_win_t c, logic [31:0] a);
        return c.en && c.siz != 3'h7 &&
               ((a[31:20] ^ c.base) & (12'hFFF << c.siz)) == 12'h000;
    endfunction : win

    // expected {ack, strobe} of one flash access
    function automatic logic [29:0] fexp(logic w, logic [31:0] a,
                                         logic [5:0] n);
        logic        top, ha, hb, ok, sel;
        logic [25:0] off;
        top = a[31:20] == 12'hFFF;
        ha = win(ca, a) || (top && ca.vec && !cb.vec);
        hb = !ha && (win(cb, a) || (top && cb.vec));
        ok = (ha ? strap[1] : strap[0]) ?
             (n == 6'h04 && a[1:0] == 2'h0) : n == 6'h01;
        off = top ? {6'h00, a[19:0]} :
              a[25:0] & ((26'h100000 << (ha ? ca.siz : cb.siz)) - 26'h1);
        sel = (ha || hb) && (!w || (ok && (ha ? ca.we : cb.we)));
        return {(ha || hb) && (!w || ok), sel && ha, sel && hb, sel && w,
                sel ? off : 26'h0};
    endfunction : fexp

    function automatic logic [31:0] img(rfw_pkg::rfw_win_t c, logic wd);
        return {c.base, wd, c.siz, 13'h0000, c.vec, c.en, c.we};
    endfunction : img

    task automatic acc(logic w, logic [31:0] a, logic [5:0] n,
                       logic [31:0] d);
        i_master.xfer(w, a, n, d, ack, rd, mem);
    endtask : acc

    task automatic reg_chk(logic b);
        acc(1'b0, b ? `RFW_ADDR_WIN_B : `RFW_ADDR_WIN_A, 6'h04, 32'h0);
        `CHECK(ack, 1'b1)
        `CHECK(rd, b ? img(cb, strap[0]) : img(ca, strap[1]))
    endtask : reg_chk

    // quiet accesses around the write keep the block idle
    task automatic reg_wr(logic b, logic [31:0] d);
        logic [31:0] a;
        a = b ? `RFW_ADDR_WIN_B : `RFW_ADDR_WIN_A;
        repeat (2) acc(1'b0, a, 6'h04, 32'h0);
        acc(1'b1, a, 6'h04, d);
        `CHECK(ack, 1'b1)
        if (b) cb = '{d[31:20], d[18:16], d[2], d[1], d[0]};
        else ca = '{d[31:20], d[18:16], d[2], d[1], d[0]};
        repeat (2) acc(1'b0, a, 6'h04, 32'h0);
        reg_chk(b);
    endtask : reg_wr

    task automatic do_reset(logic [3:0] s);
        strap <= s;
        rst_n <= 1'b0;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int k = 0; k < 20 && straps_ready !== 1'b1; k++)
            @(posedge sys_clk);
        `CHECK(straps_ready, 1'b1)
        ca = '{12'hFF0, 3'h0, s[3], 1'b0, 1'b0};
        cb = '{12'hFF4, 3'h0, s[2], 1'b0, 1'b0};
        reg_chk(1'b0);
        reg_chk(1'b1);
    endtask : do_reset

    // random windows, then random accesses at them, the top page or anywhere
    task automatic run_random(int cnt);
        logic [31:0]       r, rv, a, d;
        logic [29:0]       ex;
        logic [5:0]        n;
        rfw_pkg::rfw_win_t c;
        for (int i = 0; i < cnt; i++) begin
            if (i % 20 == 0) begin
                d = $random(seed);
                d[31:30] = 2'b00;
                reg_wr(1'b0, d);
                d = $random(seed);
                d[31:30] = 2'b01;
                reg_wr(1'b1, d);
            end
            r = $random(seed);
            rv = $random(seed);
            c = r[0] ? cb : ca;
            a = {c.base & (12'hFFF << c.siz), 20'h0} |
                (rv & ((32'h100000 << c.siz) - 32'h1));
            if (r[2:1] == 2'b11) a = {12'hFFF, rv[19:0]};
            else if (r[2:1] == 2'b10) a = $random(seed);
            n = sizes[r[7:4] % 9];
            if (r[8]) n = r[9] ? 6'h01 : 6'h04;
            if (r[10]) a[1:0] = 2'h0;
            acc(r[11], a, n, $random(seed));
            ex = fexp(r[11], a, n);
            `CHECK(ack, ex[29])
            `CHECK(mem, ex[28:0])
        end
    endtask : run_random

    initial begin
        seed = 32'hd732b85e;
        rst_n = 1'b0;
        lbr_n = 1'b1;
        strap = 4'h0;
        cycles = 0;
        do_reset(4'b1001);
        acc(1'b1, `RFW_ADDR_WIN_A, 6'h01, 32'h0);
        `CHECK(ack, 1'b0)
        run_random(300);
        // local reset leaves vector and width bits alone
        @(posedge sys_clk) lbr_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        lbr_n <= 1'b1;
        ca = '{12'hFF0, 3'h0, ca.vec, 1'b0, 1'b0};
        cb = '{12'hFF4, 3'h0, cb.vec, 1'b0, 1'b0};
        reg_chk(1'b0);
        reg_chk(1'b1);
        run_random(40);
        do_reset(4'b0110);
        run_random(300);
        final_report();
    end
endmodule : rfw_decode_bench
